// file: logic/usmp_pkg.sv
// Constants shared by the dual-channel serial and modem pin controller.
package usmp_pkg;

  // ==========================================================================
  // Register map, one word per register, channel B sits CH_STRIDE above A
  // ==========================================================================
  localparam logic [7:0] OFF_DATA  = 8'h00;
  localparam logic [7:0] OFF_IER   = 8'h04;
  localparam logic [7:0] OFF_MCR   = 8'h08;
  localparam logic [7:0] OFF_EFR   = 8'h0c;
  localparam logic [7:0] OFF_LSR   = 8'h10;
  localparam logic [7:0] OFF_MSR   = 8'h14;
  localparam logic [7:0] OFF_ISR   = 8'h18;
  localparam logic [7:0] OFF_IMR   = 8'h1c;
  localparam logic [7:0] CH_STRIDE = 8'h20;
  localparam logic [7:0] MAP_END   = 8'h40;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int MCR_DTR    = 0;
  localparam int MCR_RTS    = 1;
  localparam int MCR_IRQ_EN = 3;
  localparam int MCR_IR     = 6;
  localparam int EFR_ARTS   = 6;
  localparam int EFR_ACTS   = 7;
  localparam int IER_RTS    = 6;
  localparam int IER_CTS    = 7;
  localparam int ST_RX      = 0;
  localparam int ST_TX      = 1;
  localparam int ST_CTS     = 2;
  localparam int ST_MODEM   = 3;
  localparam int ST_RTS     = 4;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] EFR_RST = 8'h00;
  localparam logic [7:0] IMR_RST = 8'h00;
  localparam logic [4:0] PIN_RST = 5'h1f;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_HZ          = 20_000_000;
  localparam int BAUD_HZ         = 115_200;
  localparam int OVERSAMPLE      = 16;
  localparam int TICK_CYC        = CLK_HZ / (OVERSAMPLE * BAUD_HZ);
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
  localparam logic [3:0] IR_PULSE  = 4'h3;
  localparam logic [4:0] IR_HOLD   = 5'h10;
  localparam int RESET_MIN_NS    = 40;
  localparam int CLK_PERIOD_NS   = 50;
  localparam int RESET_MIN_CYC   = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    TX_IDLE  = 4'h1,
    TX_START = 4'h2,
    TX_DATA  = 4'h4,
    TX_STOP  = 4'h8
  } usmp_tx_t;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } usmp_rx_t;

endpackage

// file: logic/usmp_top.sv
// Two-channel serial line and modem pin controller behind a Wishbone slave.

module usmp_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        serial_in_a_i,
  input  wire logic        serial_in_b_i,
  input  wire logic        clear_send_n_a_i,
  input  wire logic        clear_send_n_b_i,
  input  wire logic        set_ready_n_a_i,
  input  wire logic        set_ready_n_b_i,
  input  wire logic        carrier_detect_n_a_i,
  input  wire logic        carrier_detect_n_b_i,
  input  wire logic        ring_indicator_n_a_i,
  input  wire logic        ring_indicator_n_b_i,
  output logic             serial_out_a_o,
  output logic             serial_out_b_o,
  output logic             request_send_n_a_o,
  output logic             request_send_n_b_o,
  output logic             terminal_ready_n_a_o,
  output logic             terminal_ready_n_b_o,
  output logic             user_output2_n_a_o,
  output logic             user_output2_n_b_o,
  output logic             irq_out_a_o,
  output logic             irq_out_a_oe_o,
  output logic             irq_out_b_o,
  output logic             irq_out_b_oe_o,
  output logic             rx_ready_n_b_o,
  output logic             irq_o
);

  // ==========================================================================
  // Bus slave
  // ==========================================================================
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic        irq_reg;
  logic [7:0]  div_reg;
  logic [7:0]  rd_ch [2];
  logic [4:0]  pin_raw [2];
  logic        out_tx [2];
  logic        out_rts [2];
  logic        out_dtr [2];
  logic        out_op2 [2];
  logic        out_irq [2];
  logic        out_oe [2];
  logic        out_rdy [2];
  logic        ch_irq [2];
  wire        take    = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire        mapped  = (wb_adr_i < usmp_pkg::MAP_END) & (wb_adr_i[1:0] == 2'h0);
  wire        wr_any  = take & wb_we_i & wb_sel_i[0] & mapped;
  wire        rd_any  = take & ~wb_we_i & mapped;
  wire [7:0]  loc_adr = wb_adr_i & (usmp_pkg::CH_STRIDE - 8'h01);
  wire        sel_b   = (wb_adr_i & usmp_pkg::CH_STRIDE) != 8'h00;
  wire [7:0]  rd_mux  = mapped ? (sel_b ? rd_ch[1] : rd_ch[0]) : 8'h00;
  wire        tick    = (div_reg == usmp_pkg::TICK_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      irq_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= take;
      irq_reg <= ch_irq[0] | ch_irq[1];
      if (take) begin
        dat_reg <= {24'h00_0000, rd_mux};
      end
    end
  end
  // Oversampling tick shared by both channels.
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  assign pin_raw[0] = {ring_indicator_n_a_i, carrier_detect_n_a_i, set_ready_n_a_i,
                       clear_send_n_a_i, serial_in_a_i};
  assign pin_raw[1] = {ring_indicator_n_b_i, carrier_detect_n_b_i, set_ready_n_b_i,
                       clear_send_n_b_i, serial_in_b_i};

  // ==========================================================================
  // Channels
  // ==========================================================================
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic [4:0]        s1_reg, s2_reg, s3_reg;
    logic [7:0]        ier_reg, mcr_reg, efr_reg, imr_reg, thr_reg, rxd_reg;
    logic [4:0]        isr_reg;
    logic              pend_reg, full_reg;
    usmp_pkg::usmp_tx_t tx_st_reg;
    logic [3:0]        tx_tk_reg;
    logic [2:0]        tx_bit_reg;
    logic [7:0]        tx_sh_reg;
    usmp_pkg::usmp_rx_t rx_st_reg;
    logic [3:0]        rx_tk_reg;
    logic [2:0]        rx_bit_reg;
    logic [7:0]        rx_sh_reg;
    logic [4:0]        ir_cnt_reg;
    logic              tx_out_reg, rts_n_reg, dtr_n_reg, op2_n_reg;
    logic              irq_out_reg, oe_reg, rdy_n_reg;
    wire       hit     = (sel_b == (ch == 1));
    wire       wr      = wr_any & hit;
    wire       rd_data = rd_any & hit & (loc_adr == usmp_pkg::OFF_DATA);
    wire       ir_mode = mcr_reg[usmp_pkg::MCR_IR];
    wire       cts_n   = s2_reg[1];
    wire       tx_go   = (tx_st_reg == usmp_pkg::TX_IDLE) & pend_reg &
                         ~(efr_reg[usmp_pkg::EFR_ACTS] & cts_n);
    wire       tx_end  = tick & (tx_st_reg == usmp_pkg::TX_STOP) & (tx_tk_reg == 4'hf);
    wire       tx_line = (tx_st_reg == usmp_pkg::TX_START) ? 1'b0 :
                         (tx_st_reg == usmp_pkg::TX_DATA) ? tx_sh_reg[0] : 1'b1;
    // Infrared sends a short high pulse for each zero bit and rests low.
    wire       ir_tx   = ~tx_line & (tx_tk_reg < usmp_pkg::IR_PULSE);
    wire       tx_next = ir_mode ? ir_tx : tx_line;
    // A decoded infrared pulse holds the line low until 16 ticks, one bit time, after the pulse ends.
    wire       rx_line = ir_mode ? (ir_cnt_reg == 5'h00) : s2_reg[0];
    wire       rx_done = tick & (rx_st_reg == usmp_pkg::RX_STOP) & (rx_tk_reg == 4'hf);
    wire       store   = rx_done & rx_line;
    wire       rts_nxt = ~(mcr_reg[usmp_pkg::MCR_RTS] &
                         ~(efr_reg[usmp_pkg::EFR_ARTS] & full_reg));
    wire       ev_rts  = (rts_nxt != rts_n_reg) & ier_reg[usmp_pkg::IER_RTS];
    wire       ev_cts  = (s2_reg[1] != s3_reg[1]) & ier_reg[usmp_pkg::IER_CTS];
    wire       ev_mdm  = s2_reg[4:2] != s3_reg[4:2];
    wire [4:0] events  = {ev_rts, ev_mdm, ev_cts, tx_end, store};
    wire [4:0] w1c     = (wr && loc_adr == usmp_pkg::OFF_ISR) ? wb_dat_i[4:0] : 5'h00;
    wire [7:0] lsr     = {5'h00, ir_mode, ~(tx_st_reg == usmp_pkg::TX_IDLE), full_reg};
    wire [7:0] msr     = {4'h0, ~s2_reg[4:1]};
    assign rd_ch[ch] = (loc_adr == usmp_pkg::OFF_DATA) ? rxd_reg :
                       (loc_adr == usmp_pkg::OFF_IER)  ? ier_reg :
                       (loc_adr == usmp_pkg::OFF_MCR)  ? mcr_reg :
                       (loc_adr == usmp_pkg::OFF_EFR)  ? efr_reg :
                       (loc_adr == usmp_pkg::OFF_LSR)  ? lsr :
                       (loc_adr == usmp_pkg::OFF_MSR)  ? msr :
                       (loc_adr == usmp_pkg::OFF_ISR)  ? {3'h0, isr_reg} : imr_reg;
    assign ch_irq[ch] = |(isr_reg & imr_reg[4:0]);
    // Pins from outside pass two flops; the third only feeds change detection.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        s1_reg <= usmp_pkg::PIN_RST;
        s2_reg <= usmp_pkg::PIN_RST;
        s3_reg <= usmp_pkg::PIN_RST;
      end else begin
        s1_reg <= pin_raw[ch];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
      end
    end
    // Control registers are private to this channel.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ier_reg <= usmp_pkg::IER_RST;
        mcr_reg <= usmp_pkg::MCR_RST;
        efr_reg <= usmp_pkg::EFR_RST;
        imr_reg <= usmp_pkg::IMR_RST;
        thr_reg <= 8'h00;
      end else if (wr) begin
        if (loc_adr == usmp_pkg::OFF_IER) ier_reg <= wb_dat_i[7:0];
        if (loc_adr == usmp_pkg::OFF_MCR) mcr_reg <= wb_dat_i[7:0];
        if (loc_adr == usmp_pkg::OFF_EFR) efr_reg <= wb_dat_i[7:0];
        if (loc_adr == usmp_pkg::OFF_IMR) imr_reg <= wb_dat_i[7:0];
        if (loc_adr == usmp_pkg::OFF_DATA) thr_reg <= wb_dat_i[7:0];
      end
    end
    // A fresh event wins over a clear in the same cycle.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        isr_reg  <= 5'h00;
        pend_reg <= 1'b0;
        full_reg <= 1'b0;
        rxd_reg  <= 8'h00;
      end else begin
        isr_reg  <= (isr_reg & ~w1c) | events;
        pend_reg <= (wr && loc_adr == usmp_pkg::OFF_DATA) | (pend_reg & ~tx_go);
        full_reg <= store | (full_reg & ~rd_data);
        if (store) rxd_reg <= rx_sh_reg;
      end
    end
    // Transmitter, 8 data bits, one stop bit, 16 ticks per bit.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        tx_st_reg  <= usmp_pkg::TX_IDLE;
        tx_tk_reg  <= 4'h0;
        tx_bit_reg <= 3'h0;
        tx_sh_reg  <= 8'h00;
      end else begin
        unique case (tx_st_reg)
          usmp_pkg::TX_IDLE: begin
            tx_tk_reg <= 4'h0;
            if (tx_go) begin
              tx_sh_reg <= thr_reg;
              tx_st_reg <= usmp_pkg::TX_START;
            end
          end
          usmp_pkg::TX_START: begin
            if (tick) tx_tk_reg <= tx_tk_reg + 4'h1;
            if (tick && tx_tk_reg == 4'hf) begin
              tx_bit_reg <= 3'h0;
              tx_st_reg  <= usmp_pkg::TX_DATA;
            end
          end
          usmp_pkg::TX_DATA: begin
            if (tick) tx_tk_reg <= tx_tk_reg + 4'h1;
            if (tick && tx_tk_reg == 4'hf) begin
              tx_sh_reg  <= {1'b0, tx_sh_reg[7:1]};
              tx_bit_reg <= tx_bit_reg + 3'h1;
              if (tx_bit_reg == 3'h7) tx_st_reg <= usmp_pkg::TX_STOP;
            end
          end
          usmp_pkg::TX_STOP: begin
            if (tick) tx_tk_reg <= tx_tk_reg + 4'h1;
            if (tx_end) tx_st_reg <= usmp_pkg::TX_IDLE;
          end
        endcase
      end
    end
    // Receiver samples mid-bit; a start that does not last half a bit is dropped.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        rx_st_reg  <= usmp_pkg::RX_IDLE;
        rx_tk_reg  <= 4'h0;
        rx_bit_reg <= 3'h0;
        rx_sh_reg  <= 8'h00;
        ir_cnt_reg <= 5'h00;
      end else begin
        if (s2_reg[0]) begin
          ir_cnt_reg <= usmp_pkg::IR_HOLD;
        end else if (tick && ir_cnt_reg != 5'h00) begin
          ir_cnt_reg <= ir_cnt_reg - 5'h01;
        end
        unique case (rx_st_reg)
          usmp_pkg::RX_IDLE: begin
            rx_tk_reg <= 4'h0;
            if (!rx_line) rx_st_reg <= usmp_pkg::RX_START;
          end
          usmp_pkg::RX_START: begin
            if (tick) rx_tk_reg <= rx_tk_reg + 4'h1;
            if (tick && rx_tk_reg == 4'h7) begin
              rx_tk_reg  <= 4'h0;
              rx_bit_reg <= 3'h0;
              rx_st_reg  <= rx_line ? usmp_pkg::RX_IDLE : usmp_pkg::RX_DATA;
            end
          end
          usmp_pkg::RX_DATA: begin
            if (tick) rx_tk_reg <= rx_tk_reg + 4'h1;
            if (tick && rx_tk_reg == 4'hf) begin
              rx_sh_reg  <= {rx_line, rx_sh_reg[7:1]};
              rx_bit_reg <= rx_bit_reg + 3'h1;
              if (rx_bit_reg == 3'h7) rx_st_reg <= usmp_pkg::RX_STOP;
            end
          end
          usmp_pkg::RX_STOP: begin
            if (tick) rx_tk_reg <= rx_tk_reg + 4'h1;
            if (rx_done) rx_st_reg <= usmp_pkg::RX_IDLE;
          end
        endcase
      end
    end
    // Pin drivers, each from its own flop.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        tx_out_reg  <= 1'b1;
        rts_n_reg   <= 1'b1;
        dtr_n_reg   <= 1'b1;
        op2_n_reg   <= 1'b1;
        irq_out_reg <= 1'b0;
        oe_reg      <= 1'b0;
        rdy_n_reg   <= 1'b1;
      end else begin
        tx_out_reg  <= tx_next;
        rts_n_reg   <= rts_nxt;
        dtr_n_reg   <= ~mcr_reg[usmp_pkg::MCR_DTR];
        op2_n_reg   <= ~mcr_reg[usmp_pkg::MCR_IRQ_EN];
        irq_out_reg <= ch_irq[ch];
        oe_reg      <= mcr_reg[usmp_pkg::MCR_IRQ_EN];
        rdy_n_reg   <= ~full_reg;
      end
    end
    assign out_tx[ch]  = tx_out_reg;
    assign out_rts[ch] = rts_n_reg;
    assign out_dtr[ch] = dtr_n_reg;
    assign out_op2[ch] = op2_n_reg;
    assign out_irq[ch] = irq_out_reg;
    assign out_oe[ch]  = oe_reg;
    assign out_rdy[ch] = rdy_n_reg;
  end

  // ==========================================================================
  // Port wiring
  // ==========================================================================
  assign wb_ack_o             = ack_reg;
  assign wb_dat_o             = dat_reg;
  assign irq_o                = irq_reg;
  assign serial_out_a_o       = out_tx[0];
  assign serial_out_b_o       = out_tx[1];
  assign request_send_n_a_o   = out_rts[0];
  assign request_send_n_b_o   = out_rts[1];
  assign terminal_ready_n_a_o = out_dtr[0];
  assign terminal_ready_n_b_o = out_dtr[1];
  assign user_output2_n_a_o   = out_op2[0];
  assign user_output2_n_b_o   = out_op2[1];
  assign irq_out_a_o          = out_irq[0];
  assign irq_out_a_oe_o       = out_oe[0];
  assign irq_out_b_o          = out_irq[1];
  assign irq_out_b_oe_o       = out_oe[1];
  assign rx_ready_n_b_o       = out_rdy[1];

endmodule

// file: test/usmp_properties.sv
// Port-level concurrent checks for the serial and modem pin controller.
module usmp_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        serial_out_a_o,
  input wire logic        serial_out_b_o,
  input wire logic        request_send_n_a_o,
  input wire logic        terminal_ready_n_a_o,
  input wire logic        terminal_ready_n_b_o,
  input wire logic        user_output2_n_a_o,
  input wire logic        user_output2_n_b_o,
  input wire logic        irq_out_a_o,
  input wire logic        irq_out_a_oe_o,
  input wire logic        irq_out_b_o,
  input wire logic        irq_out_b_oe_o,
  input wire logic        rx_ready_n_b_o,
  input wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Decode of taken control writes
  // ==========================================================================
  wire logic take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  wire logic wr_mcr_a = take && wb_adr_i == usmp_pkg::OFF_MCR;
  wire logic wr_mcr_b = take && wb_adr_i == usmp_pkg::OFF_MCR + usmp_pkg::CH_STRIDE;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================================
  // Sequences
  // ==========================================================================
  sequence rd_data_b;
    wb_ack_o && wb_cyc_i && !wb_we_i && wb_adr_i == usmp_pkg::OFF_DATA + usmp_pkg::CH_STRIDE;
  endsequence
  sequence irq_quiet;
    (!irq_out_a_o && !irq_out_b_o) [*3];
  endsequence

  // ==========================================================================
  // Assertions
  // ==========================================================================
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held high");
  ack_answer_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not acked");
  dat_upper_a:
    assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
  op2_oe_a:
    assert property (irq_out_a_oe_o != user_output2_n_a_o) else $error("op2 a disagrees with enable");
  op2_oe_b_a:
    assert property (irq_out_b_oe_o != user_output2_n_b_o) else $error("op2 b disagrees with enable");
  reset_out_a:
    assert property (disable iff (1'b0) rst_i |=> serial_out_a_o && serial_out_b_o && request_send_n_a_o
      && terminal_ready_n_a_o && user_output2_n_a_o && !irq_out_a_oe_o && rx_ready_n_b_o)
      else $error("outputs not at reset level");
  tx_idle_a:
    assert property ($fell(rst_i) |-> (serial_out_a_o && serial_out_b_o) [*3]) else $error("tx not idle high");
  rx_ready_a:
    assert property (rd_data_b |-> ##[1:2] rx_ready_n_b_o) else $error("rx ready stuck after read");
  mcr_pins_a:
    assert property ($changed({terminal_ready_n_a_o, user_output2_n_a_o}) |->
      $past(wr_mcr_a) || $past(wr_mcr_a, 2) || $past(rst_i)) else $error("a pins moved without write");
  mcr_pins_b_a:
    assert property ($changed({terminal_ready_n_b_o, user_output2_n_b_o}) |->
      $past(wr_mcr_b) || $past(wr_mcr_b, 2) || $past(rst_i)) else $error("b pins moved without write");
  irq_rise_a:
    assert property ($rose(irq_out_a_o) |-> ##[0:2] irq_o) else $error("irq summary missed");
  irq_quiet_a:
    assert property (irq_quiet |-> !irq_o) else $error("irq summary without source");
endmodule

// file: test/usmp_partner.sv
// Behavioural serial line partner: sends frames, captures frames, drives clear-to-send.
module usmp_partner (
  input  wire logic clk_i,
  input  wire logic serial_out_i,
  output logic      serial_in_o,
  output logic      clear_send_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT_CYC   = usmp_pkg::TICK_CYC * usmp_pkg::OVERSAMPLE;
  localparam int PULSE_CYC = usmp_pkg::TICK_CYC * int'(usmp_pkg::IR_PULSE);

  initial begin
    serial_in_o = 1'b1;
    clear_send_n_o = 1'b0;
  end

  task automatic cts(input logic v);
    clear_send_n_o <= v;
  endtask

  task automatic line(input logic v);
    serial_in_o <= v;
  endtask

  // Infrared zero bits are a short high pulse; the line rests low otherwise.
  task automatic send(input logic [7:0] b, input logic ir, input int gap);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    repeat (gap) @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      serial_in_o <= ir ? !f[i] : f[i];
      if (ir) begin
        repeat (PULSE_CYC) @(posedge clk_i);
        serial_in_o <= 1'b0;
      end
      repeat (ir ? BIT_CYC - PULSE_CYC : BIT_CYC) @(posedge clk_i);
    end
  endtask

  // A zero bit shows as low in plain mode and as high in infrared mode.
  task automatic catch_frame(input logic ir, output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (serial_out_i !== ir && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    repeat (15) @(posedge clk_i);
    for (int k = 0; k < 9; k++) begin
      repeat (BIT_CYC) @(posedge clk_i);
      if (k < 8) b[k] = serial_out_i !== ir;
    end
    ok = n < 3000 && serial_out_i !== ir;
  endtask
endmodule

// file: test/tb.sv
// Top testbench for the serial and modem pin controller.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] B_DATA = usmp_pkg::OFF_DATA + usmp_pkg::CH_STRIDE;
  localparam logic [7:0] B_MCR  = usmp_pkg::OFF_MCR + usmp_pkg::CH_STRIDE;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rdat;
  logic        wb_ack_o, sin_a, sin_b, cts_a, cts_b, dsr_a = 1'b1, cd_a = 1'b1, ri_a = 1'b1;
  logic        dsr_b = 1'b1, cd_b = 1'b1, ri_b = 1'b1;
  logic        serial_out_a_o, serial_out_b_o, rts_a, rts_b, dtr_a, dtr_b, op2_a, op2_b;
  logic        irq_out_a_o, irq_out_b_o, oe_a, oe_b, rx_ready_n_b_o, irq_o, ok;
  logic [7:0]  got;
  int          miscompares = 0;
  int          n_tests = 0;
  wire  [7:0]  pins = {dtr_a, dtr_b, rts_a, rts_b, op2_a, op2_b, oe_a, oe_b};

  always #25 clk_i = !clk_i;

  usmp_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .serial_in_a_i(sin_a), .serial_in_b_i(sin_b), .clear_send_n_a_i(cts_a), .clear_send_n_b_i(cts_b),
    .set_ready_n_a_i(dsr_a), .set_ready_n_b_i(dsr_b), .carrier_detect_n_a_i(cd_a),
    .carrier_detect_n_b_i(cd_b), .ring_indicator_n_a_i(ri_a), .ring_indicator_n_b_i(ri_b),
    .serial_out_a_o(serial_out_a_o), .serial_out_b_o(serial_out_b_o), .request_send_n_a_o(rts_a),
    .request_send_n_b_o(rts_b), .terminal_ready_n_a_o(dtr_a), .terminal_ready_n_b_o(dtr_b),
    .user_output2_n_a_o(op2_a), .user_output2_n_b_o(op2_b), .irq_out_a_o(irq_out_a_o),
    .irq_out_a_oe_o(oe_a), .irq_out_b_o(irq_out_b_o), .irq_out_b_oe_o(oe_b),
    .rx_ready_n_b_o(rx_ready_n_b_o), .irq_o(irq_o));
  usmp_partner pa (.clk_i(clk_i), .serial_out_i(serial_out_a_o), .serial_in_o(sin_a), .clear_send_n_o(cts_a));
  usmp_partner pb (.clk_i(clk_i), .serial_out_i(serial_out_b_o), .serial_in_o(sin_b), .clear_send_n_o(cts_b));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic single cycle: request held until ack is sampled, then released for a cycle.
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    check(rdat, {24'h0, exp});
  endtask

  // Mode switches can leave a stray byte, so the holding register is emptied first.
  task automatic rx_case(input logic ir, input logic [7:0] b, input int gap);
    wb(1'b1, B_MCR, {1'b0, ir, 6'h02});
    pb.line(!ir);
    repeat (3000) @(posedge clk_i);
    wb(1'b0, B_DATA, 8'h00);
    pb.send(b, ir, gap);
    repeat (4) @(posedge clk_i);
    check({rx_ready_n_b_o, rts_b}, 2'h1);
    rd(B_DATA, b);
    repeat (3) @(posedge clk_i);
    check({rx_ready_n_b_o, rts_b}, 2'h2);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({serial_out_a_o, serial_out_b_o, rx_ready_n_b_o, irq_o}, 4'he);
    check(pins, 8'hfc);
    rd(usmp_pkg::OFF_MCR, 8'h00);
    wb(1'b1, usmp_pkg::MAP_END, 8'hff);
    rd(usmp_pkg::MAP_END, 8'h00);
    $display("reset test done");
    for (int c = 0; c < 2; c++) begin
      wb(1'b1, c ? B_MCR : usmp_pkg::OFF_MCR, 8'h0b);
      repeat (3) @(posedge clk_i);
      check(pins, c ? 8'ha9 : 8'h56);
      wb(1'b1, c ? B_MCR : usmp_pkg::OFF_MCR, 8'h00);
      repeat (3) @(posedge clk_i);
      check(pins, 8'hfc);
    end
    $display("modem output test done");
    dsr_a <= 1'b0;
    cd_a <= 1'b0;
    ri_a <= 1'b0;
    repeat (6) @(posedge clk_i);
    rd(usmp_pkg::OFF_MSR, 8'h0f);
    rd(usmp_pkg::OFF_MSR + usmp_pkg::CH_STRIDE, 8'h01);
    ri_b <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(usmp_pkg::OFF_MSR + usmp_pkg::CH_STRIDE, 8'h09);
    check(serial_out_a_o, 1'b1);
    $display("modem input test done");
    wb(1'b1, usmp_pkg::OFF_DATA, 8'ha5);
    pa.catch_frame(1'b0, got, ok);
    check({ok, got}, 9'h1a5);
    repeat (200) @(posedge clk_i);
    check(serial_out_a_o, 1'b1);
    wb(1'b1, usmp_pkg::OFF_IER, 8'h80);
    wb(1'b1, usmp_pkg::OFF_EFR, 8'h80);
    pa.cts(1'b1);
    wb(1'b1, usmp_pkg::OFF_DATA, 8'h3c);
    repeat (400) @(posedge clk_i);
    check(serial_out_a_o, 1'b1);
    pa.cts(1'b0);
    pa.catch_frame(1'b0, got, ok);
    check({ok, got}, 9'h13c);
    $display("transmit test done");
    rd(usmp_pkg::OFF_ISR, 8'h0e);
    wb(1'b1, usmp_pkg::OFF_MCR, 8'h08);
    wb(1'b1, usmp_pkg::OFF_IMR, 8'h02);
    repeat (3) @(posedge clk_i);
    check({irq_out_a_o, irq_o, oe_a, op2_a}, 4'he);
    wb(1'b1, usmp_pkg::OFF_ISR, 8'h02);
    repeat (3) @(posedge clk_i);
    check({irq_out_a_o, irq_o, oe_a, op2_a}, 4'h2);
    rd(usmp_pkg::OFF_ISR, 8'h0c);
    $display("interrupt test done");
    wb(1'b1, B_MCR, 8'h40);
    pb.line(1'b0);
    repeat (4) @(posedge clk_i);
    check(serial_out_b_o, 1'b0);
    wb(1'b1, B_DATA, 8'h5a);
    pb.catch_frame(1'b1, got, ok);
    check({ok, got, serial_out_b_o}, 10'h2b4);
    wb(1'b1, usmp_pkg::OFF_EFR + usmp_pkg::CH_STRIDE, 8'h40);
    rx_case(1'b1, 8'hc3, 10);
    rx_case(1'b0, 8'h96, 500);
    wb(1'b1, usmp_pkg::OFF_IMR + usmp_pkg::CH_STRIDE, 8'h01);
    repeat (3) @(posedge clk_i);
    check({irq_out_b_o, irq_o}, 2'h3);
    $display("receive test done");
    wb(1'b1, usmp_pkg::OFF_MCR, 8'h0b);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({pins, serial_out_a_o, serial_out_b_o}, 10'h3f3);
    $display("mid-run reset test done");
    wrap_up();
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    wrap_up();
  end
endmodule

bind usmp_top usmp_properties u_props (.*);
